/* src/bpm_pkg.sv */
`default_nettype none
package bpm_pkg;

    // ========================================================
    // register map (byte addresses)
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_DBR    = 5'h04;
    localparam logic [4:0] ADDR_DBF    = 5'h08;
    localparam logic [4:0] ADDR_SRCEN  = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // ========================================================
    // control register fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_MODE_LSB  = 1;
    localparam int CTRL_REV_BIT   = 4;
    localparam int CTRL_DBREN_BIT = 5;
    localparam int CTRL_DBFEN_BIT = 6;

    // ========================================================
    // status register fields
    localparam int STAT_OUT_LSB   = 0;
    localparam int STAT_ODD_BIT   = 8;
    localparam int STAT_BUSY_BIT  = 9;
    localparam int STAT_QUAL_BIT  = 10;
    localparam int STAT_DIR_BIT   = 11;

    // ========================================================
    // output bit positions inside the six-bit output word
    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_C = 2;
    localparam int OUT_D = 3;
    localparam int OUT_E = 4;
    localparam int OUT_F = 5;

    // ========================================================
    // reset values
    localparam logic [7:0] DB_RST    = 8'h00;
    localparam logic [5:0] OUT_RST   = 6'h00;
    localparam logic [2:0] MODE_RST  = 3'h0;

    // ========================================================
    // output modes
    typedef enum logic [2:0] {
        MODE_OFF  = 3'b000,
        MODE_PP4  = 3'b001,
        MODE_PP6  = 3'b010,
        MODE_SKIP = 3'b011,
        MODE_SKPC = 3'b100,
        MODE_FBL  = 3'b101
    } bpm_mode_e;

endpackage
`default_nettype wire

/* src/bpm_deadband.sv */
`default_nettype none
module bpm_deadband (
    input  wire logic       clk_sys_i,  // system clock
    input  wire logic       rst_n_i,    // sync reset, active low
    input  wire logic       clr_i,      // abandon a running delay
    input  wire logic       start_i,    // load and start a delay
    input  wire logic [7:0] count_i,    // delay length in cycles
    output logic            busy_o,     // delay running
    output logic            done_o      // one-cycle end pulse
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       done;
    } bpm_db_s;

    bpm_db_s st_q;
    bpm_db_s st_d;

    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (clr_i) begin
            st_d.cnt = 8'h00;
        end else if (start_i) begin
            st_d.cnt = count_i;
        end else if (st_q.cnt != 8'h00) begin
            st_d.cnt = st_q.cnt - 8'h01;
            if (st_q.cnt == 8'h01) begin
                st_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy_o = (st_q.cnt != 8'h00);
    assign done_o = st_q.done;

    // delay of n cycles ends with done n+1 cycles after the start
    db_length_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (start_i && !clr_i && count_i == 8'h02)
        |=> busy_o ##1 (busy_o && !done_o) ##1 (done_o && !busy_o)
    ) else $error("dead-band delay length wrong");

endmodule
`default_nettype wire

/* src/bpm_bridge_pwm.sv */
`default_nettype none
module bpm_bridge_pwm #(
    parameter int SRC_W = 4  // number of rising-edge sources
) (
    input  wire logic             clk_sys_i,          // system clock
    input  wire logic             rst_n_i,            // sync reset, low
    input  wire logic [4:0]       avs_address,        // byte address
    input  wire logic             avs_read,           // read request
    input  wire logic             avs_write,          // write request
    input  wire logic [31:0]      avs_writedata,      // write data
    output logic      [31:0]      avs_readdata,       // read data
    output logic                  avs_waitrequest,    // stall master
    input  wire logic             period_evt_i,       // period event
    input  wire logic             rise_evt_i,         // rising edge event
    input  wire logic             fall_evt_i,         // falling edge event
    input  wire logic [SRC_W-1:0] rise_src_i,         // rising sources
    output logic                  bridge_out_a_o,     // output A
    output logic                  bridge_out_b_o,     // output B
    output logic                  bridge_out_c_o,     // output C
    output logic                  bridge_out_d_o,     // output D
    output logic                  bridge_out_e_o,     // output E
    output logic                  bridge_out_f_o      // output F
);

    localparam logic [5:0] M_A  = 6'h01;
    localparam logic [5:0] M_B  = 6'h02;
    localparam logic [5:0] M_C  = 6'h04;
    localparam logic [5:0] M_D  = 6'h08;
    localparam logic [5:0] M_E  = 6'h10;
    localparam logic [5:0] M_F  = 6'h20;

    typedef struct packed {
        logic                ack;
        logic [31:0]         rdata;
        logic                en;
        bpm_pkg::bpm_mode_e  mode;
        logic                rev;
        logic                dbr_en;
        logic                dbf_en;
        logic [7:0]          dbr;
        logic [7:0]          dbf;
        logic [SRC_W-1:0]    srcen;
        logic                run;
        bpm_pkg::bpm_mode_e  mode_app;
        logic                rev_app;
        logic                odd;
        logic                qual;
        logic [5:0]          outs;
        logic [5:0]          pend;
    } bpm_state_s;

    bpm_state_s st_q;
    bpm_state_s st_d;

    logic       db_start;
    logic [7:0] db_count;
    logic       db_clr;
    logic       db_busy;
    logic       db_done;
    logic       odd_eff;
    logic       qual_eff;
    logic       settled;
    logic [5:0] set_m;
    logic [5:0] clr_m;
    logic       use_db;
    logic       use_rise;

    bpm_deadband u_deadband (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .clr_i     (db_clr),
        .start_i   (db_start),
        .count_i   (db_count),
        .busy_o    (db_busy),
        .done_o    (db_done)
    );

    assign settled = st_q.run && st_q.en && (st_q.mode_app == st_q.mode);

    always_comb begin
        st_d     = st_q;
        db_start = 1'b0;
        db_clr   = 1'b0;
        set_m    = 6'h00;
        clr_m    = 6'h00;
        use_db   = 1'b0;
        use_rise = 1'b0;
        // parity flips on every period event
        odd_eff  = period_evt_i ? !st_q.odd : st_q.odd;
        // sample the sources at the period event
        qual_eff = period_evt_i ? |(rise_src_i & st_q.srcen) : st_q.qual;
        db_count = 8'h00;

        // ====================================================
        // avalon slave
        st_d.ack = (avs_read || avs_write) && !st_q.ack;
        if (avs_read && !st_q.ack) begin
            st_d.rdata = 32'h0000_0000;
            if (avs_address == bpm_pkg::ADDR_CTRL) begin
                st_d.rdata[bpm_pkg::CTRL_EN_BIT] = st_q.en;
                st_d.rdata[bpm_pkg::CTRL_MODE_LSB +: 3] = st_q.mode;
                st_d.rdata[bpm_pkg::CTRL_REV_BIT] = st_q.rev;
                st_d.rdata[bpm_pkg::CTRL_DBREN_BIT] = st_q.dbr_en;
                st_d.rdata[bpm_pkg::CTRL_DBFEN_BIT] = st_q.dbf_en;
            end else if (avs_address == bpm_pkg::ADDR_DBR) begin
                st_d.rdata[7:0] = st_q.dbr;
            end else if (avs_address == bpm_pkg::ADDR_DBF) begin
                st_d.rdata[7:0] = st_q.dbf;
            end else if (avs_address == bpm_pkg::ADDR_SRCEN) begin
                st_d.rdata[SRC_W-1:0] = st_q.srcen;
            end else if (avs_address == bpm_pkg::ADDR_STATUS) begin
                st_d.rdata[bpm_pkg::STAT_OUT_LSB +: 6] = st_q.outs;
                st_d.rdata[bpm_pkg::STAT_ODD_BIT] = st_q.odd;
                st_d.rdata[bpm_pkg::STAT_BUSY_BIT] = db_busy;
                st_d.rdata[bpm_pkg::STAT_QUAL_BIT] = st_q.qual;
                st_d.rdata[bpm_pkg::STAT_DIR_BIT] = st_q.rev_app;
            end
        end
        if (avs_write && st_q.ack) begin
            if (avs_address == bpm_pkg::ADDR_CTRL) begin
                st_d.en = avs_writedata[bpm_pkg::CTRL_EN_BIT];
                st_d.mode = bpm_pkg::bpm_mode_e'(
                    avs_writedata[bpm_pkg::CTRL_MODE_LSB +: 3]);
                st_d.rev = avs_writedata[bpm_pkg::CTRL_REV_BIT];
                st_d.dbr_en = avs_writedata[bpm_pkg::CTRL_DBREN_BIT];
                st_d.dbf_en = avs_writedata[bpm_pkg::CTRL_DBFEN_BIT];
            end else if (avs_address == bpm_pkg::ADDR_DBR) begin
                st_d.dbr = avs_writedata[7:0];
            end else if (avs_address == bpm_pkg::ADDR_DBF) begin
                st_d.dbf = avs_writedata[7:0];
            end else if (avs_address == bpm_pkg::ADDR_SRCEN) begin
                st_d.srcen = avs_writedata[SRC_W-1:0];
            end
        end

        // ====================================================
        // waveform engine
        if (!settled) begin
            // disabled or mode changed: clear and restart odd
            db_clr       = 1'b1;
            st_d.run     = st_q.en;
            st_d.mode_app = st_q.mode;
            st_d.rev_app = st_q.rev;
            st_d.odd     = 1'b1;
            st_d.qual    = 1'b0;
            st_d.pend    = 6'h00;
            st_d.outs    = bpm_pkg::OUT_RST;
            if (st_q.en && st_q.mode == bpm_pkg::MODE_FBL) begin
                st_d.outs = st_q.rev ? M_C : M_D;
            end
        end else begin
            st_d.odd  = odd_eff;
            st_d.qual = qual_eff;
            if (db_done) begin
                st_d.outs = st_d.outs | st_q.pend;
                st_d.pend = 6'h00;
            end
            case (st_q.mode)
                bpm_pkg::MODE_PP4: begin
                    // A,C and B,D switch as pairs
                    // no dead band, E and F unused
                    if (fall_evt_i) begin
                        clr_m = odd_eff ? (M_A | M_C) : (M_B | M_D);
                    end else if (rise_evt_i) begin
                        set_m = odd_eff ? (M_A | M_C) : (M_B | M_D);
                    end
                end
                bpm_pkg::MODE_PP6: begin
                    if (fall_evt_i) begin
                        // odd fall, A,C off then E on
                        // even fall, B,D off then F on
                        clr_m  = odd_eff ? (M_A | M_C) : (M_B | M_D);
                        set_m  = odd_eff ? M_E : M_F;
                        use_db = st_q.dbf_en;
                    end else if (rise_evt_i) begin
                        // odd rise, E off then A,C on
                        // even rise, F off then B,D on
                        clr_m    = odd_eff ? M_E : M_F;
                        set_m    = odd_eff ? (M_A | M_C) : (M_B | M_D);
                        use_db   = st_q.dbr_en;
                        use_rise = 1'b1;
                    end
                end
                bpm_pkg::MODE_SKIP: begin
                    // A is the only output here
                    if (fall_evt_i) begin
                        clr_m = M_A;
                    end else if (rise_evt_i && qual_eff) begin
                        // rise comes from the phase-time event
                        set_m     = M_A;
                        st_d.qual = 1'b0;
                    end
                end
                bpm_pkg::MODE_SKPC: begin
                    // primary on A, complement on B
                    if (fall_evt_i) begin
                        clr_m  = M_A;
                        set_m  = M_B;
                        use_db = st_q.dbf_en;
                    end else if (rise_evt_i && qual_eff) begin
                        // B off, dead band, A on
                        clr_m     = M_B;
                        set_m     = M_A;
                        use_db    = st_q.dbr_en;
                        use_rise  = 1'b1;
                        st_d.qual = 1'b0;
                    end
                end
                bpm_pkg::MODE_FBL: begin
                    if (st_q.rev != st_q.rev_app) begin
                        // dead band only on direction change
                        st_d.rev_app = st_q.rev;
                        clr_m    = M_A | M_B | M_C | M_D;
                        set_m    = st_q.rev ? M_C : M_D;
                        use_rise = !st_q.rev;
                        use_db   = st_q.rev ? st_q.dbf_en : st_q.dbr_en;
                    end else if (fall_evt_i) begin
                        clr_m = st_q.rev_app ? M_B : M_A;
                    end else if (rise_evt_i) begin
                        set_m = st_q.rev_app ? M_B : M_A;
                    end
                end
                default: clr_m = 6'h00;
            endcase
            db_count = use_rise ? st_q.dbr : st_q.dbf;
            if (clr_m != 6'h00 || set_m != 6'h00) begin
                st_d.outs = st_d.outs & ~clr_m;
                st_d.pend = 6'h00;
                if (use_db && db_count != 8'h00) begin
                    db_start  = 1'b1;
                    st_d.pend = set_m;
                end else begin
                    st_d.outs = st_d.outs | set_m;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_q          <= '0;
            st_q.mode     <= bpm_pkg::bpm_mode_e'(bpm_pkg::MODE_RST);
            st_q.mode_app <= bpm_pkg::bpm_mode_e'(bpm_pkg::MODE_RST);
            st_q.dbr      <= bpm_pkg::DB_RST;
            st_q.dbf      <= bpm_pkg::DB_RST;
            st_q.outs     <= bpm_pkg::OUT_RST;
            st_q.odd      <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // outputs
    assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
    assign avs_readdata    = st_q.rdata;
    assign bridge_out_a_o  = st_q.outs[bpm_pkg::OUT_A];
    assign bridge_out_b_o  = st_q.outs[bpm_pkg::OUT_B];
    assign bridge_out_c_o  = st_q.outs[bpm_pkg::OUT_C];
    assign bridge_out_d_o  = st_q.outs[bpm_pkg::OUT_D];
    assign bridge_out_e_o  = st_q.outs[bpm_pkg::OUT_E];
    assign bridge_out_f_o  = st_q.outs[bpm_pkg::OUT_F];

    // ========================================================
    // checks
    pp4_pairs_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_PP4)
        |-> (bridge_out_a_o == bridge_out_c_o &&
             bridge_out_b_o == bridge_out_d_o &&
             !bridge_out_e_o && !bridge_out_f_o)
    ) else $error("four-output push-pull pairs differ");
    pp4_odd_rise_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_PP4 && rise_evt_i &&
         !fall_evt_i && odd_eff && !(avs_write && st_q.ack))
        |=> (bridge_out_a_o && bridge_out_c_o)
    ) else $error("odd rise did not set A and C");
    pp4_even_fall_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_PP4 && fall_evt_i &&
         !odd_eff && !(avs_write && st_q.ack))
        |=> (!bridge_out_b_o && !bridge_out_d_o)
    ) else $error("even fall did not clear B and D");
    pp6_overlap_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_PP6)
        |-> !(bridge_out_e_o && (bridge_out_a_o || bridge_out_c_o)) &&
            !(bridge_out_f_o && (bridge_out_b_o || bridge_out_d_o))
    ) else $error("primary and complement overlap");
    pp6_nogap_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_PP6 && !st_q.dbf_en &&
         fall_evt_i && odd_eff && !(avs_write && st_q.ack))
        |=> (bridge_out_e_o && !bridge_out_a_o && !bridge_out_c_o)
    ) else $error("swap without dead band not immediate");
    skip_only_a_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_SKIP)
        |-> (st_q.outs[5:1] == 5'h00)
    ) else $error("single skip mode drove other pins");
    skip_unqual_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_SKIP && rise_evt_i &&
         !fall_evt_i && !qual_eff && !(avs_write && st_q.ack))
        |=> $stable(bridge_out_a_o)
    ) else $error("unqualified period made a pulse");
    fb_forward_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_FBL && !st_q.rev_app &&
         st_q.pend == 6'h00 && !db_busy)
        |-> (bridge_out_d_o && !bridge_out_b_o && !bridge_out_c_o)
    ) else $error("forward statics wrong");
    fb_reverse_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && st_q.mode == bpm_pkg::MODE_FBL && st_q.rev_app &&
         st_q.pend == 6'h00 && !db_busy)
        |-> (bridge_out_c_o && !bridge_out_a_o && !bridge_out_d_o)
    ) else $error("reverse statics wrong");
    parity_flip_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        (settled && period_evt_i && !(avs_write && st_q.ack))
        |=> (st_q.odd != $past(st_q.odd))
    ) else $error("parity did not toggle");
    bus_wait_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        ((avs_read || avs_write) && avs_waitrequest)
        |=> !avs_waitrequest
    ) else $error("bus answer not after one wait cycle");
endmodule
`default_nettype wire

/* verification/bpm_bridge_stage.sv */
`default_nettype none
module bpm_bridge_stage (
    input  wire logic       clk_sys_i,  // system clock
    input  wire logic [5:0] drive_i,    // gate drives F..A
    output logic      [7:0] shoot_o     // cycles with a leg shorted
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================
    // both switches of one leg on at once, either stage
    initial shoot_o = 8'h00;
    always @(posedge clk_sys_i) begin
        if ((drive_i[0] & drive_i[4]) | (drive_i[1] & drive_i[5]) |
            (drive_i[0] & drive_i[1]) | (drive_i[2] & drive_i[3])) begin
            shoot_o <= shoot_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* verification/bpm_bridge_pwm_tb.sv */
`default_nettype none
module bpm_bridge_pwm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i;
    logic        rst_n_i;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  evt;
    logic [3:0]  rise_src;
    wire  [5:0]  outs;
    logic [7:0]  shoot;
    int          err_total;
    int          checks;

    bpm_bridge_pwm #(.SRC_W(4)) i_bpm_bridge_pwm (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .period_evt_i(evt[2]), .rise_evt_i(evt[1]), .fall_evt_i(evt[0]),
        .rise_src_i(rise_src),
        .bridge_out_a_o(outs[0]), .bridge_out_b_o(outs[1]),
        .bridge_out_c_o(outs[2]), .bridge_out_d_o(outs[3]),
        .bridge_out_e_o(outs[4]), .bridge_out_f_o(outs[5])
    );
    bpm_bridge_stage i_bpm_bridge_stage (
        .clk_sys_i(clk_sys_i), .drive_i(outs), .shoot_o(shoot)
    );

    // ========================================================
    // shared tasks
    task automatic end_sim;
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk(input logic [5:0] e);
        cmp("outputs", {26'h0, e}, {26'h0, outs});
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys_i);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp("register", e, q);
    endtask
    task automatic mode(input logic [31:0] c);
        wr(bpm_pkg::ADDR_CTRL, c);
        repeat (2) @(posedge clk_sys_i);
    endtask
    // events are {period, rise, fall}
    task automatic ev(input logic [2:0] e);
        @(posedge clk_sys_i);
        evt <= e;
        @(posedge clk_sys_i);
        evt <= 3'h0;
        #1;
    endtask
    task automatic src(input logic [3:0] s);
        @(posedge clk_sys_i);
        rise_src <= s;
    endtask
    // rise with two-cycle dead band: hold, then the final set
    task automatic rise_db(input logic [5:0] hold, input logic [5:0] fin);
        ev(3'h2);
        chk(hold);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(hold);
        @(posedge clk_sys_i);
        #1;
        chk(fin);
    endtask

    // ========================================================
    // scenarios
    task automatic t_reset;
        chk(6'h00);
        rd(bpm_pkg::ADDR_CTRL, 32'h0);
        wr(5'h14, 32'hFFFFFFFF);
        rd(5'h14, 32'h0);
    endtask
    task automatic t_pp4;
        logic [31:0] q;
        mode(32'h03);
        rd(bpm_pkg::ADDR_CTRL, 32'h03);
        ev(3'h2); chk(6'h05);
        ev(3'h1); chk(6'h00);
        ev(3'h4);
        bus(1'b0, bpm_pkg::ADDR_STATUS, 32'h0, q);
        cmp("parity", 32'h0, {31'h0, q[bpm_pkg::STAT_ODD_BIT]});
        ev(3'h2); chk(6'h0A);
        ev(3'h1); chk(6'h00);
        ev(3'h6); chk(6'h05);
    endtask
    task automatic t_pp6;
        wr(bpm_pkg::ADDR_DBR, 32'h02);
        rd(bpm_pkg::ADDR_DBR, 32'h02);
        mode(32'h25);
        rise_db(6'h00, 6'h05);
        ev(3'h1); chk(6'h10);
        ev(3'h4);
        rise_db(6'h10, 6'h1A);
        ev(3'h1); chk(6'h30);
    endtask
    task automatic t_skip;
        wr(bpm_pkg::ADDR_SRCEN, 32'h01);
        rd(bpm_pkg::ADDR_SRCEN, 32'h01);
        mode(32'h07);
        src(4'h2);
        ev(3'h4); ev(3'h2); chk(6'h00);
        src(4'h1);
        ev(3'h4);
        src(4'h0);
        ev(3'h2); chk(6'h01);
        ev(3'h1); chk(6'h00);
        ev(3'h1); chk(6'h00);
        mode(32'h09);
        src(4'h1);
        ev(3'h4); ev(3'h2); chk(6'h01);
        ev(3'h1); chk(6'h02);
    endtask
    task automatic t_fbl;
        mode(32'h0B);
        chk(6'h08);
        ev(3'h2); chk(6'h09);
        ev(3'h1); chk(6'h08);
        mode(32'h1B);
        chk(6'h04);
        ev(3'h2); chk(6'h06);
        ev(3'h1); chk(6'h04);
        rd(bpm_pkg::ADDR_STATUS, 32'h0904);
        wr(bpm_pkg::ADDR_DBF, 32'h03);
        rd(bpm_pkg::ADDR_DBF, 32'h03);
        mode(32'h4B); chk(6'h08);
        mode(32'h5B); chk(6'h00);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(6'h00);
        @(posedge clk_sys_i);
        #1;
        chk(6'h04);
        mode(32'h00); chk(6'h00);
    endtask

    // ========================================================
    // clock, main sequence and watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_n_i       = 1'b0;
        avs_address   = 5'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        evt           = 3'h0;
        rise_src      = 4'h0;
        err_total     = 0;
        checks        = 0;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_pp4;
        t_pp6;
        t_skip;
        t_fbl;
        cmp("overlap", 32'h0, {24'h0, shoot});
        end_sim;
    end
    initial begin
        #100000;
        err_total++;
        end_sim;
    end
endmodule
`default_nettype wire
